// *** core/prm_consts.svh ***
// Named constants for the program memory table read block.
// Assumes inclusion by the package and the main module only.
`ifndef PRM_CONSTS_SVH
`define PRM_CONSTS_SVH

// Pointer geometry
`define PRM_PTR_W 22
`define PRM_SPACE_BIT 21
`define PRM_UPPER_USED 6
`define PRM_WORD_ADDR_W 20

// Reset values
`define PRM_PTR_RST 22'h00_0000
`define PRM_LAT_RST 8'h00
`define PRM_BYTE_ZERO 8'h00
`define PRM_UPPER_PAD 2'h0

// Table write occupies two instruction cycles; counter starts one below
`define PRM_TABLE_WRITE_INSTR_CNT_INIT 2'h1
`define PRM_CNT_ZERO 2'h0

`endif

// *** core/prm_pkg.sv ***
// Types shared by the program memory table read block.
// Assumes prm_consts.svh is on the include path.
`include "prm_consts.svh"

package prm_pkg;

   // Special function register select
   typedef enum logic [1:0] {
      PRM_SFR_UPPER = 2'b00,
      PRM_SFR_HIGH  = 2'b01,
      PRM_SFR_LOW   = 2'b10,
      PRM_SFR_LATCH = 2'b11
   } prm_sfr_t;

   // Table instruction variants issued by the core
   typedef enum logic [2:0] {
      PRM_OP_READ       = 3'b000,
      PRM_OP_READ_PINC  = 3'b001,
      PRM_OP_READ_PDEC  = 3'b010,
      PRM_OP_READ_PREINC = 3'b011,
      PRM_OP_WRITE      = 3'b100
   } prm_op_t;

   // Sequencer states
   typedef enum logic [1:0] {
      PRM_S_IDLE  = 2'b00,
      PRM_S_FETCH = 2'b01,
      PRM_S_WRNOP = 2'b10
   } prm_fsm_t;

   // Register access from the core
   typedef struct packed {
      logic wr;
      logic rd;
      prm_sfr_t sel;
      logic [7:0] wdata;
   } prm_sfr_req_t;

   // Instruction request from the core
   typedef struct packed {
      logic valid;
      prm_op_t op;
   } prm_instr_t;

   // Answer from program memory
   typedef struct packed {
      logic ack;
      logic [15:0] rdata;
   } prm_mem_rsp_t;

   // Whole state of the main module
   typedef struct packed {
      prm_fsm_t fsm;
      prm_op_t mode;
      logic [`PRM_PTR_W-1:0] ptr;
      logic [`PRM_PTR_W-1:0] fetch;
      logic [7:0] latch;
      logic [7:0] rdata;
      logic [1:0] cnt;
      logic req;
      logic busy;
      logic done;
   } prm_state_t;

endpackage

// *** core/prm_ptr_step.sv ***
// Pointer increment and decrement confined to the low space bits.
// Assumes a pointer whose top bit selects configuration space.
module prm_ptr_step #(
   parameter int PTR_W = 22
) (
   // Current pointer
   input wire logic [PTR_W-1:0] ptr_i,
   // Stepped pointers, top bit kept
   output logic [PTR_W-1:0] ptr_inc_o,
   output logic [PTR_W-1:0] ptr_dec_o
);

   // Low bits wrap on their own; the space bit is carried across untouched
   assign ptr_inc_o = {ptr_i[PTR_W-1], ptr_i[PTR_W-2:0] + 1'b1};
   assign ptr_dec_o = {ptr_i[PTR_W-1], ptr_i[PTR_W-2:0] - 1'b1};

endmodule

// *** core/prm_table_read.sv ***
// Program memory table read: pointer registers, read latch, sequencer.
// Assumes the core issues one table instruction at a time, waits for
// done_o, and that program memory answers a held request with an ack.
`include "prm_consts.svh"

// How it works
// - Pointer is upper bits 5:0, high byte and low byte: 22 bits.
// - With bit 21 clear, bits 20:0 address the 2 Mbyte program space.
// - With bit 21 set, the read targets configuration space instead.
// - Read modes: unchanged, post-increment, post-decrement, pre-increment.
// - Pointer steps change bits 20:0 only, never bit 21.
// - All 22 pointer bits choose the byte that is fetched.
// - Each read moves exactly one byte into the latch.
// - Pointer bit 0 picks low or high byte of the memory word.
// - Unimplemented upper pointer bits read back as zero.
// - The read latch is an 8-bit register software reads and writes.
// - Program memory is 16 bits wide; latch and data are 8 bits.
// - A table write takes two cycles and does nothing else.
module prm_table_read (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // Register access from the core
   input wire prm_pkg::prm_sfr_req_t sfr_i,
   output logic [7:0] sfr_rdata_o,
   // Table instructions from the core
   input wire prm_pkg::prm_instr_t instr_i,
   output logic busy_o,
   output logic done_o,
   // Program memory port
   output logic mem_req_o,
   output logic [`PRM_WORD_ADDR_W-1:0] mem_word_addr_o,
   output logic mem_cfg_space_o,
   input wire prm_pkg::prm_mem_rsp_t mem_i
);
   import prm_pkg::*;

   prm_state_t q;
   prm_state_t d;
   logic [`PRM_PTR_W-1:0] ptr_inc;
   logic [`PRM_PTR_W-1:0] ptr_dec;
   logic [7:0] fetched_byte;
   logic accept;

   // Pointer arithmetic shared by pre and post steps
   prm_ptr_step #(
      .PTR_W(`PRM_PTR_W)
   ) u_step (
      .ptr_i(q.ptr),
      .ptr_inc_o(ptr_inc),
      .ptr_dec_o(ptr_dec)
   );

   // Byte lane of the returned 16-bit word
   prm_byte_pick u_pick (
      .word_i(mem_i.rdata),
      .odd_i(q.fetch[0]),
      .byte_o(fetched_byte)
   );

   // An instruction is taken only from idle. The done cycle already counts as idle,
   // so the core may issue back to back without a dead cycle; anything given while
   // busy is dropped silently, which is why the core must wait for done_o
   assign accept = instr_i.valid && (q.fsm == PRM_S_IDLE);

   // Next state: register access first, then the sequencer, so that a
   // hardware pointer update overrides a software write in the same cycle
   always_comb begin
      d = q;
      d.done = 1'b0;
      // Software reads
      if (sfr_i.rd) begin
         case (sfr_i.sel)
            PRM_SFR_UPPER: d.rdata = {`PRM_UPPER_PAD, q.ptr[`PRM_PTR_W-1:16]};
            PRM_SFR_HIGH: d.rdata = q.ptr[15:8];
            PRM_SFR_LOW: d.rdata = q.ptr[7:0];
            PRM_SFR_LATCH: d.rdata = q.latch;
            default: d.rdata = `PRM_BYTE_ZERO;
         endcase
      end
      // Software writes; upper bits 7:6 are dropped
      if (sfr_i.wr) begin
         case (sfr_i.sel)
            PRM_SFR_UPPER: d.ptr[`PRM_PTR_W-1:16] = sfr_i.wdata[`PRM_UPPER_USED-1:0];
            PRM_SFR_HIGH: d.ptr[15:8] = sfr_i.wdata;
            PRM_SFR_LOW: d.ptr[7:0] = sfr_i.wdata;
            PRM_SFR_LATCH: d.latch = sfr_i.wdata;
            default: d.latch = q.latch;
         endcase
      end
      // Sequencer
      case (q.fsm)
         PRM_S_IDLE: begin
            if (accept) begin
               d.mode = instr_i.op;
               d.busy = 1'b1;
               if (instr_i.op == PRM_OP_WRITE) begin
                  d.fsm = PRM_S_WRNOP;
                  d.cnt = `PRM_TABLE_WRITE_INSTR_CNT_INIT;
               end else begin
                  d.fsm = PRM_S_FETCH;
                  d.req = 1'b1;
                  if (instr_i.op == PRM_OP_READ_PREINC) begin
                     d.ptr = ptr_inc;
                     d.fetch = ptr_inc;
                  end else begin
                     d.fetch = q.ptr;
                  end
               end
            end
         end
         PRM_S_FETCH: begin
            // Request is held until memory acknowledges it; latency is not bounded
            // here, so a memory that never answers stalls the core
            if (mem_i.ack) begin
               d.req = 1'b0;
               d.latch = fetched_byte;
               d.busy = 1'b0;
               d.done = 1'b1;
               d.fsm = PRM_S_IDLE;
               if (q.mode == PRM_OP_READ_PINC) begin
                  d.ptr = ptr_inc;
               end else if (q.mode == PRM_OP_READ_PDEC) begin
                  d.ptr = ptr_dec;
               end
            end
         end
         PRM_S_WRNOP: begin
            // Memory stays untouched; only the cycles are spent. The counter keeps
            // the two-cycle timing even though nothing is written
            if (q.cnt == `PRM_CNT_ZERO) begin
               d.busy = 1'b0;
               d.done = 1'b1;
               d.fsm = PRM_S_IDLE;
            end else begin
               d.cnt = q.cnt - 1'b1;
            end
         end
         default: begin
            d.fsm = PRM_S_IDLE;
            d.req = 1'b0;
            d.busy = 1'b0;
         end
      endcase
   end

   // State register
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         q.fsm <= PRM_S_IDLE;
         q.mode <= PRM_OP_READ;
         q.ptr <= `PRM_PTR_RST;
         q.fetch <= `PRM_PTR_RST;
         q.latch <= `PRM_LAT_RST;
         q.rdata <= `PRM_BYTE_ZERO;
         q.cnt <= `PRM_CNT_ZERO;
         q.req <= 1'b0;
         q.busy <= 1'b0;
         q.done <= 1'b0;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from state; word address drops the byte-select bit
   assign sfr_rdata_o = q.rdata;
   assign busy_o = q.busy;
   assign done_o = q.done;
   assign mem_req_o = q.req;
   assign mem_word_addr_o = q.fetch[`PRM_SPACE_BIT-1:1];
   assign mem_cfg_space_o = q.fetch[`PRM_SPACE_BIT];

   // Checks
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!resetn_i);

   logic upper_wr;
   logic hw_step;
   assign upper_wr = sfr_i.wr && (sfr_i.sel == PRM_SFR_UPPER);

   // Cycles in which the sequencer owns the pointer, so a software write is lost
   assign hw_step = (accept && instr_i.op == PRM_OP_READ_PREINC)
      || (q.fsm == PRM_S_FETCH && mem_i.ack
          && (q.mode == PRM_OP_READ_PINC || q.mode == PRM_OP_READ_PDEC));

   space_bit_kept_a: assert property (
      !upper_wr |=> q.ptr[`PRM_SPACE_BIT] == $past(q.ptr[`PRM_SPACE_BIT]))
      else $error("pointer space bit changed without an upper write");

   post_inc_a: assert property (
      (q.fsm == PRM_S_FETCH && mem_i.ack && q.mode == PRM_OP_READ_PINC)
      |=> q.ptr[`PRM_SPACE_BIT-1:0] == $past(q.fetch[`PRM_SPACE_BIT-1:0]) + 21'h01)
      else $error("post increment did not step the pointer by one");

   post_dec_a: assert property (
      (q.fsm == PRM_S_FETCH && mem_i.ack && q.mode == PRM_OP_READ_PDEC)
      |=> q.ptr[`PRM_SPACE_BIT-1:0] == $past(q.fetch[`PRM_SPACE_BIT-1:0]) - 21'h01)
      else $error("post decrement did not step the pointer down by one");

   pre_inc_a: assert property (
      (accept && instr_i.op == PRM_OP_READ_PREINC)
      |=> mem_req_o && q.fetch == q.ptr
          && q.fetch[`PRM_SPACE_BIT-1:0] == $past(q.ptr[`PRM_SPACE_BIT-1:0]) + 21'h01)
      else $error("pre increment did not fetch the stepped address");

   fetch_addr_a: assert property (
      (accept && instr_i.op != PRM_OP_WRITE && instr_i.op != PRM_OP_READ_PREINC)
      |=> mem_req_o && {mem_cfg_space_o, mem_word_addr_o} == $past(q.ptr[`PRM_PTR_W-1:1]))
      else $error("fetch address differs from the pointer");

   latch_byte_a: assert property (
      (q.fsm == PRM_S_FETCH && mem_i.ack)
      |=> done_o && q.latch == ($past(q.fetch[0]) ? $past(mem_i.rdata[15:8])
                                                  : $past(mem_i.rdata[7:0])))
      else $error("latch took the wrong byte of the word");

   upper_read_a: assert property (
      (sfr_i.rd && sfr_i.sel == PRM_SFR_UPPER)
      |=> sfr_rdata_o[7:6] == `PRM_UPPER_PAD
          && sfr_rdata_o[5:0] == $past(q.ptr[`PRM_PTR_W-1:16]))
      else $error("upper pointer read wrong");

   write_nop_a: assert property (
      (accept && instr_i.op == PRM_OP_WRITE)
      |=> (busy_o && !mem_req_o && !done_o) ##1 (busy_o && !mem_req_o)
          ##1 (done_o && !busy_o && !mem_req_o))
      else $error("table write did not take two idle cycles");

   // Sequencer checks
   one_byte_a: assert property (
      (q.fsm == PRM_S_FETCH && mem_i.ack)
      |=> !mem_req_o && !busy_o && done_o ##1 !done_o)
      else $error("a read did not end after one byte");

   req_start_a: assert property (
      $rose(mem_req_o) |-> $past(accept))
      else $error("memory request started without an instruction");

   busy_start_a: assert property (
      accept |=> busy_o && !done_o)
      else $error("accepted instruction did not raise busy");

   req_hold_a: assert property (
      (mem_req_o && !mem_i.ack)
      |=> mem_req_o && $stable(mem_word_addr_o) && $stable(mem_cfg_space_o))
      else $error("fetch address moved before memory answered");

   done_idle_a: assert property (
      done_o |-> !busy_o && !mem_req_o)
      else $error("done given while still busy");

   idle_quiet_a: assert property (
      (q.fsm == PRM_S_IDLE) |-> !busy_o && !mem_req_o)
      else $error("idle sequencer shows busy or a request");

   plain_read_a: assert property (
      (q.fsm == PRM_S_FETCH && mem_i.ack && q.mode == PRM_OP_READ && !sfr_i.wr)
      |=> $stable(q.ptr))
      else $error("plain read moved the pointer");

   // Register checks; writes that meet a pointer step are left out, hardware wins
   upper_write_a: assert property (
      (upper_wr && !hw_step)
      |=> q.ptr[`PRM_PTR_W-1:16] == $past(sfr_i.wdata[`PRM_UPPER_USED-1:0]))
      else $error("upper pointer write lost");

   high_write_a: assert property (
      (sfr_i.wr && sfr_i.sel == PRM_SFR_HIGH && !hw_step)
      |=> q.ptr[15:8] == $past(sfr_i.wdata))
      else $error("high pointer write lost");

   low_write_a: assert property (
      (sfr_i.wr && sfr_i.sel == PRM_SFR_LOW && !hw_step)
      |=> q.ptr[7:0] == $past(sfr_i.wdata))
      else $error("low pointer write lost");

   latch_write_a: assert property (
      (sfr_i.wr && sfr_i.sel == PRM_SFR_LATCH && !(q.fsm == PRM_S_FETCH && mem_i.ack))
      |=> q.latch == $past(sfr_i.wdata))
      else $error("latch write lost");

   latch_read_a: assert property (
      (sfr_i.rd && sfr_i.sel == PRM_SFR_LATCH)
      |=> sfr_rdata_o == $past(q.latch))
      else $error("latch read wrong");

   write_quiet_a: assert property (
      (q.fsm == PRM_S_WRNOP && !(sfr_i.wr && sfr_i.sel == PRM_SFR_LATCH))
      |=> $stable(q.latch) && !mem_req_o)
      else $error("table write touched the latch or memory");

   // Main scenarios worth seeing in a run
   cov_post_inc_c: cover property (accept && instr_i.op == PRM_OP_READ_PINC ##[1:20] done_o);
   cov_cfg_read_c: cover property (mem_req_o && mem_cfg_space_o && mem_i.ack);
   cov_wrap_c: cover property (q.fsm == PRM_S_FETCH && mem_i.ack
      && q.mode == PRM_OP_READ_PDEC && q.fetch[`PRM_SPACE_BIT-1:0] == 21'h00_0000);
   cov_write_c: cover property (accept && instr_i.op == PRM_OP_WRITE);
   cov_preinc_c: cover property (accept && instr_i.op == PRM_OP_READ_PREINC && q.ptr[21]);

endmodule

// *** core/prm_byte_pick.sv ***
// Byte lane selection from a 16-bit program memory word.
// Assumes the low byte of the word sits at the even byte address.
module prm_byte_pick (
   // Word and lane select
   input wire logic [15:0] word_i,
   input wire logic odd_i,
   // Selected byte
   output logic [7:0] byte_o
);

   // Odd byte address takes the upper half
   assign byte_o = odd_i ? word_i[15:8] : word_i[7:0];

endmodule

// *** tb/prm_mem_model.sv ***
// Program memory model that answers the block's word requests.
// Assumes the requester holds req, address and space bit until it samples ack.
module prm_mem_model (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // Request from the block
   input wire logic req_i,
   input wire logic [19:0] word_addr_i,
   input wire logic cfg_i,
   // Extra wait cycles before the answer
   input wire logic [3:0] dly_i,
   // Answer to the block
   output prm_pkg::prm_mem_rsp_t mem_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import prm_pkg::*;
   logic [3:0] wait_q;

   // One ack per request; the space bit flips every data bit so both spaces differ
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wait_q <= 4'h0;
         mem_o <= '0;
      end else if (req_i && !mem_o.ack && wait_q >= dly_i) begin
         wait_q <= 4'h0;
         mem_o.ack <= 1'b1;
         mem_o.rdata <= {~word_addr_i[7:0], word_addr_i[7:0]} ^ {16{cfg_i}};
      end else begin
         wait_q <= (req_i && !mem_o.ack) ? wait_q + 4'h1 : 4'h0;
         mem_o.ack <= 1'b0;
         mem_o.rdata <= ~mem_o.rdata; // Stale data is inverted every cycle while no answer is given
      end
   end
endmodule

// *** tb/tb_prm_table_read.sv ***
// Self-checking bench for the program memory table read block.
// Assumes the memory model answers each held request after dly cycles.
module tb_prm_table_read;
   timeunit 1ns;
   timeprecision 1ps;
   import prm_pkg::*;
   logic ref_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   prm_sfr_req_t sfr = '0;
   prm_instr_t instr = '0;
   prm_mem_rsp_t mem;
   logic [7:0] sfr_rdata;
   logic busy, done, mem_req, cfg;
   logic [19:0] waddr;
   logic [20:0] fetch_v;
   logic [3:0] dly = 4'h0;
   int num_errors = 0;
   int samples_checked = 0;

   // Clock of 8 ns
   always #4 ref_clk_i = ~ref_clk_i;

   prm_table_read i_dut (
      .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .sfr_i(sfr), .sfr_rdata_o(sfr_rdata),
      .instr_i(instr), .busy_o(busy), .done_o(done), .mem_req_o(mem_req),
      .mem_word_addr_o(waddr), .mem_cfg_space_o(cfg), .mem_i(mem)
   );
   prm_mem_model i_mem (
      .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .req_i(mem_req), .word_addr_i(waddr),
      .cfg_i(cfg), .dly_i(dly), .mem_o(mem)
   );

   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic final_report();
      $display("checked %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Register accesses leave one idle cycle so a strobe never rises in the step it fell
   task automatic sfr_wr(input prm_sfr_t sel, input logic [7:0] data);
      sfr.wr = 1'b1;
      sfr.sel = sel;
      sfr.wdata = data;
      @(negedge ref_clk_i);
      sfr.wr = 1'b0;
      @(negedge ref_clk_i);
   endtask

   task automatic sfr_rd(input prm_sfr_t sel, output logic [7:0] data);
      sfr.rd = 1'b1;
      sfr.sel = sel;
      @(negedge ref_clk_i);
      sfr.rd = 1'b0;
      data = sfr_rdata;
      @(negedge ref_clk_i);
   endtask

   task automatic set_ptr(input logic [21:0] p);
      sfr_wr(PRM_SFR_UPPER, {2'h3, p[21:16]}); // Junk in the top bits must be dropped
      sfr_wr(PRM_SFR_HIGH, p[15:8]);
      sfr_wr(PRM_SFR_LOW, p[7:0]);
   endtask

   task automatic get_ptr(output logic [21:0] p);
      logic [7:0] u, h, l;
      sfr_rd(PRM_SFR_UPPER, u);
      sfr_rd(PRM_SFR_HIGH, h);
      sfr_rd(PRM_SFR_LOW, l);
      check("upper pad", {16'h0000, u}, {16'h0000, 2'h0, u[5:0]});
      p = {u[5:0], h, l};
   endtask

   // Issue one instruction, note the fetch address, wait boundedly for done
   task automatic issue(input prm_op_t op, output int cycles);
      fetch_v = 21'h1F_FFFF;
      instr.valid = 1'b1;
      instr.op = op;
      @(negedge ref_clk_i);
      instr.valid = 1'b0;
      check("busy after take", {23'h00_0000, busy}, 24'h00_0001);
      cycles = 1;
      while (done !== 1'b1 && cycles < 40) begin
         if (mem_req === 1'b1) fetch_v = {cfg, waddr};
         @(negedge ref_clk_i);
         cycles++;
      end
      check("done seen", {23'h00_0000, done}, 24'h00_0001);
   endtask

   function automatic logic [7:0] byte_at(input logic [21:0] p);
      logic [15:0] w;
      w = {~p[8:1], p[8:1]} ^ {16{p[21]}};
      return p[0] ? w[15:8] : w[7:0];
   endfunction

   task automatic t_reset();
      logic [21:0] p;
      logic [7:0] v;
      get_ptr(p);
      check("reset pointer", {2'h0, p}, 24'h00_0000);
      sfr_rd(PRM_SFR_LATCH, v);
      check("reset latch", {16'h0000, v}, 24'h00_0000);
      sfr_wr(PRM_SFR_LATCH, 8'hC5);
      sfr_rd(PRM_SFR_LATCH, v);
      check("latch write", {16'h0000, v}, 24'h00_00C5);
      $display("test reset done");
   endtask

   // Every read mode, the three stepping ones at a wrap boundary, with growing memory delay
   task automatic t_modes();
      prm_op_t ops[4] = '{PRM_OP_READ, PRM_OP_READ_PINC, PRM_OP_READ_PDEC, PRM_OP_READ_PREINC};
      logic [21:0] starts[4] = '{22'h15_5AA1, 22'h1F_FFFF, 22'h20_0000, 22'h3F_FFFF};
      logic [21:0] s, nxt, fe, en, p;
      logic [20:0] st;
      logic [7:0] v;
      int cyc;
      for (int i = 0; i < 4; i++) begin
         s = starts[i];
         st = (ops[i] == PRM_OP_READ_PDEC) ? 21'h1F_FFFF : 21'h00_0001;
         nxt = {s[21], s[20:0] + st};
         fe = (ops[i] == PRM_OP_READ_PREINC) ? nxt : s;
         en = (ops[i] == PRM_OP_READ) ? s : nxt;
         dly = 4'(i * 2);
         set_ptr(s);
         issue(ops[i], cyc);
         check("fetch address", {3'h0, fetch_v}, {3'h0, fe[21:1]});
         sfr_rd(PRM_SFR_LATCH, v);
         check("latch byte", {16'h0000, v}, {16'h0000, byte_at(fe)});
         get_ptr(p);
         check("pointer after", {2'h0, p}, {2'h0, en});
      end
      $display("test modes done");
   endtask

   // Second read given in the done cycle of the first
   task automatic t_b2b();
      logic [21:0] p;
      logic [7:0] v;
      int cyc;
      dly = 4'h1;
      set_ptr(22'h00_0101);
      issue(PRM_OP_READ_PINC, cyc);
      issue(PRM_OP_READ_PINC, cyc);
      sfr_rd(PRM_SFR_LATCH, v);
      check("second byte", {16'h0000, v}, {16'h0000, byte_at(22'h00_0102)});
      get_ptr(p);
      check("pointer twice", {2'h0, p}, 24'h00_0103);
      $display("test back to back done");
   endtask

   task automatic t_write();
      logic [21:0] p;
      logic [7:0] v;
      int cyc;
      sfr_wr(PRM_SFR_LATCH, 8'h5C);
      issue(PRM_OP_WRITE, cyc);
      check("write cycles", 24'(cyc), 24'h00_0003);
      check("busy at done", {23'h00_0000, busy}, 24'h00_0000);
      check("no fetch", {3'h0, fetch_v}, 24'h1F_FFFF);
      sfr_rd(PRM_SFR_LATCH, v);
      check("latch kept", {16'h0000, v}, 24'h00_005C);
      get_ptr(p);
      check("pointer kept", {2'h0, p}, 24'h00_0103);
      $display("test write done");
   endtask

   // Main sequence
   initial begin
      repeat (6) @(negedge ref_clk_i);
      resetn_i = 1'b1;
      @(negedge ref_clk_i);
      t_reset();
      t_modes();
      t_b2b();
      t_write();
      final_report();
   end

   // Watchdog well beyond the roughly 135 cycles the tests need
   initial begin
      #40000;
      num_errors++;
      final_report();
   end
endmodule
